// ---- core/gcirq_top.sv ----
// Added by the designer: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Raise tx ready when data register empty
// - Flags sticky; write zero clears that bit
// - Set remote abort on remote report
// - Byte written during abort is discarded
// - Set CI change on valid received byte
// - Transmit reset level sensitive, reinitialises transmit
// - Transmit reset clears ready, keeps underrun
// - Receive reset clears flags, drops frames
// - After receive reset, wait next flag
// - Monitor reset reinitialises both directions
// - Monitor reset clears six channel flags
// - GCI clock sixty-four n frame rate
// - Double clock sixteen n frame rate
// - Single clock eight n frame rate
module gcirq_top (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [3:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    input wire logic link_clk_in,
    input wire logic frame_sync_in,
    input wire logic link_data_in,
    input wire logic [1:0] remote_abort_in,
    input wire logic tx_underrun_in,
    input wire logic tx_pool_free_in,
    input wire logic rx_msg_end_in,
    input wire logic rx_pool_full_in,
    input wire logic rx_overflow_in,
    input wire logic rx_line_flag_in,
    output logic link_data_out,
    output logic tx_reset_out,
    output logic rx_reset_out,
    output logic rx_active_out
);
    // Two-stage synchronisers for pins
    logic [6:0] sync1;
    logic [6:0] sync2;
    logic [6:0] pin_raw;
    assign pin_raw = {rx_line_flag_in, remote_abort_in, tx_pool_free_in,
                      link_data_in, frame_sync_in, link_clk_in};
    // Underrun, message-end, pool-full and overflow pins carry no sync here; they come from same-clock logic
    logic clk_prev;
    logic next_clk_prev;
    logic link_rise;
    logic fs_s;
    logic data_s;
    assign link_rise = sync2[0] & ~clk_prev;
    assign fs_s = sync2[1];
    assign data_s = sync2[2];

    logic [7:0] status0;
    logic [7:0] status_ch [2];
    logic [7:0] command;
    logic [7:0] config_reg;
    logic [7:0] mon_tx [2];
    logic [7:0] ci_rx [2];
    logic [7:0] mon_rx [2];
    logic [7:0] ci_prev [2];
    logic [7:0] shift;
    logic [3:0] bit_cnt;
    logic [1:0] mon_full;
    logic [7:0] tx_shift;
    logic rx_hunt;
    logic [31:0] rdata;
    logic wait_q;

    logic [7:0] next_status0;
    logic [7:0] next_status_ch [2];
    logic [7:0] next_command;
    logic [7:0] next_config;
    logic [7:0] next_mon_tx [2];
    logic [7:0] next_ci_rx [2];
    logic [7:0] next_mon_rx [2];
    logic [7:0] next_ci_prev [2];
    logic [7:0] next_shift;
    logic [3:0] next_bit_cnt;
    logic [1:0] next_mon_full;
    logic [7:0] next_tx_shift;
    logic next_rx_hunt;
    logic [31:0] next_rdata;
    logic next_wait;

    // Write-zero-to-clear mask for a sticky flag register
    function automatic logic [7:0] clr_mask(input logic hit, input logic [7:0] wd);
        clr_mask = hit ? wd : 8'hFF;
    endfunction : clr_mask

    logic access;
    logic wr;
    logic [7:0] wd;
    assign access = (avs_read_in | avs_write_in) & wait_q;
    assign wr = avs_write_in & wait_q;
    assign wd = avs_writedata_in[7:0];

    logic tx_rst;
    logic rx_rst;
    logic [1:0] mci_rst;
    assign tx_rst = command[gcirq_pkg::BIT_TX_RESET];
    assign rx_rst = command[gcirq_pkg::BIT_RX_RESET];
    assign mci_rst = {command[gcirq_pkg::BIT_MCI_RESET2],
                      command[gcirq_pkg::BIT_MCI_RESET1]};

    always_comb begin
        next_clk_prev = sync2[0];
        next_command = command;
        next_config = config_reg;
        next_shift = shift;
        next_bit_cnt = bit_cnt;
        next_tx_shift = tx_shift;
        next_rx_hunt = rx_hunt;
        next_wait = 1'b1;
        next_rdata = rdata;
        next_mon_full = mon_full;
        next_status0 = status0;
        for (int c = 0; c < 2; c++) begin
            next_status_ch[c] = status_ch[c];
            next_mon_tx[c] = mon_tx[c];
            next_ci_rx[c] = ci_rx[c];
            next_mon_rx[c] = mon_rx[c];
            next_ci_prev[c] = ci_prev[c];
        end
        // Bus: one wait cycle, answer on second
        if (access) begin
            next_wait = 1'b0;
        end
        if (access && avs_read_in) begin
            case (avs_address_in)
                gcirq_pkg::ADDR_IRQ_STATUS0: next_rdata = {24'h00_0000, status0};
                gcirq_pkg::ADDR_IRQ_STATUS1: next_rdata = {24'h00_0000, status_ch[0]};
                gcirq_pkg::ADDR_IRQ_STATUS2: next_rdata = {24'h00_0000, status_ch[1]};
                gcirq_pkg::ADDR_COMMAND: next_rdata = {24'h00_0000, command};
                gcirq_pkg::ADDR_MON_TX1: next_rdata = {24'h00_0000, mon_tx[0]};
                gcirq_pkg::ADDR_MON_TX2: next_rdata = {24'h00_0000, mon_tx[1]};
                gcirq_pkg::ADDR_CI_RX1: next_rdata = {24'h00_0000, ci_rx[0]};
                gcirq_pkg::ADDR_CI_RX2: next_rdata = {24'h00_0000, ci_rx[1]};
                gcirq_pkg::ADDR_MON_RX1: next_rdata = {24'h00_0000, mon_rx[0]};
                gcirq_pkg::ADDR_MON_RX2: next_rdata = {24'h00_0000, mon_rx[1]};
                gcirq_pkg::ADDR_CONFIG: next_rdata = {24'h00_0000, config_reg};
                default: next_rdata = 32'h0000_0000;
            endcase
        end
        // Clears first, so hardware sets below win
        if (wr) begin
            next_status0 = status0 & clr_mask(avs_address_in == gcirq_pkg::ADDR_IRQ_STATUS0, wd);
            next_status_ch[0] = status_ch[0] & clr_mask(avs_address_in == gcirq_pkg::ADDR_IRQ_STATUS1, wd);
            next_status_ch[1] = status_ch[1] & clr_mask(avs_address_in == gcirq_pkg::ADDR_IRQ_STATUS2, wd);
            if (avs_address_in == gcirq_pkg::ADDR_COMMAND) begin
                next_command = wd;
            end
            if (avs_address_in == gcirq_pkg::ADDR_CONFIG) begin
                next_config = wd;
            end
            for (int c = 0; c < 2; c++) begin
                if (avs_address_in == (gcirq_pkg::ADDR_MON_TX1 + 4'(c))) begin
                    if (!status_ch[c][gcirq_pkg::BIT_REMOTE_ABORT] && !mci_rst[c]) begin
                        next_mon_tx[c] = wd;
                        next_mon_full[c] = 1'b1;
                    end
                end
            end
        end
        // Pool and error events
        if (tx_underrun_in) begin
            next_status0[gcirq_pkg::BIT_TX_UNDERRUN] = 1'b1;
        end
        if (sync2[3] && !tx_rst) begin
            next_status0[gcirq_pkg::BIT_TX_POOL_READY] = 1'b1;
        end
        if (!rx_rst && !rx_hunt) begin
            if (rx_msg_end_in) next_status0[gcirq_pkg::BIT_RX_MSG_END] = 1'b1;
            if (rx_pool_full_in) next_status0[gcirq_pkg::BIT_RX_POOL_FULL] = 1'b1;
            if (rx_overflow_in) next_status0[gcirq_pkg::BIT_RX_OVERFLOW] = 1'b1;
        end
        if (tx_rst) begin
            next_status0[gcirq_pkg::BIT_TX_POOL_READY] = 1'b0;
        end
        if (rx_rst) begin
            next_status0[gcirq_pkg::BIT_RX_MSG_END] = 1'b0;
            next_status0[gcirq_pkg::BIT_RX_POOL_FULL] = 1'b0;
            next_status0[gcirq_pkg::BIT_RX_OVERFLOW] = 1'b0;
            next_rx_hunt = 1'b1;
        end else if (rx_hunt && sync2[6]) begin
            next_rx_hunt = 1'b0;
        end
        // Link slot: 8 bits after frame sync, bit count marks slot end
        if (link_rise) begin
            if (fs_s) begin
                next_bit_cnt = 4'h0;
            end else if (bit_cnt < 4'(gcirq_pkg::SLOT_BITS)) begin
                next_bit_cnt = bit_cnt + 4'h1;
            end
            next_shift = {shift[6:0], data_s};
            // Shift in ones so the line idles high between bytes
            next_tx_shift = {tx_shift[6:0], 1'b1};
            if (fs_s) begin
                for (int c = 0; c < 2; c++) begin
                    if (mon_full[c] && !mci_rst[c]) begin
                        next_tx_shift = mon_tx[c];
                        next_mon_full[c] = 1'b0;
                    end
                end
            end
            if (bit_cnt == 4'(gcirq_pkg::SLOT_BITS - 1)) begin
                for (int c = 0; c < 2; c++) begin
                    if (!mci_rst[c] && (c == int'(config_reg[gcirq_pkg::BIT_CLOCK_MODE]))) begin
                        if (next_shift == ci_prev[c] && next_shift != ci_rx[c]) begin
                            next_ci_rx[c] = next_shift;
                            next_status_ch[c][gcirq_pkg::BIT_CI_CHANGE] = 1'b1;
                        end
                        next_ci_prev[c] = next_shift;
                        next_mon_rx[c] = next_shift;
                    end
                end
            end
        end
        for (int c = 0; c < 2; c++) begin
            if (sync2[4 + c] && !mci_rst[c]) begin
                next_status_ch[c][gcirq_pkg::BIT_REMOTE_ABORT] = 1'b1;
            end
            if (!mon_full[c] && !next_mon_full[c] && !mci_rst[c]) begin
                next_status_ch[c][gcirq_pkg::BIT_MON_TX_READY] = 1'b1;
            end
            if (mci_rst[c]) begin
                next_status_ch[c] = gcirq_pkg::RESET_STATUS;
                next_mon_full[c] = 1'b0;
                next_ci_prev[c] = 8'h00;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            sync1 <= 7'h00;
            sync2 <= 7'h00;
            clk_prev <= 1'b0;
            status0 <= gcirq_pkg::RESET_STATUS;
            command <= gcirq_pkg::RESET_COMMAND;
            config_reg <= gcirq_pkg::RESET_CONFIG;
            shift <= 8'h00;
            bit_cnt <= 4'h0;
            tx_shift <= 8'hFF;
            rx_hunt <= 1'b0;
            rdata <= 32'h0000_0000;
            wait_q <= 1'b1;
            mon_full <= 2'b00;
            for (int c = 0; c < 2; c++) begin
                status_ch[c] <= gcirq_pkg::RESET_STATUS;
                mon_tx[c] <= 8'h00;
                ci_rx[c] <= 8'h00;
                mon_rx[c] <= 8'h00;
                ci_prev[c] <= 8'h00;
            end
        end else begin
            sync1 <= pin_raw;
            sync2 <= sync1;
            clk_prev <= next_clk_prev;
            status0 <= next_status0;
            command <= next_command;
            config_reg <= next_config;
            shift <= next_shift;
            bit_cnt <= next_bit_cnt;
            tx_shift <= next_tx_shift;
            rx_hunt <= next_rx_hunt;
            rdata <= next_rdata;
            wait_q <= next_wait;
            mon_full <= next_mon_full;
            for (int c = 0; c < 2; c++) begin
                status_ch[c] <= next_status_ch[c];
                mon_tx[c] <= next_mon_tx[c];
                ci_rx[c] <= next_ci_rx[c];
                mon_rx[c] <= next_mon_rx[c];
                ci_prev[c] <= next_ci_prev[c];
            end
        end
    end

    logic rst_tx_q;
    logic rst_rx_q;
    logic active_q;
    logic data_q;
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            rst_tx_q <= 1'b0;
            rst_rx_q <= 1'b0;
            active_q <= 1'b0;
            data_q <= 1'b1;
        end else begin
            rst_tx_q <= next_command[gcirq_pkg::BIT_TX_RESET];
            rst_rx_q <= next_command[gcirq_pkg::BIT_RX_RESET];
            active_q <= ~next_rx_hunt & ~next_command[gcirq_pkg::BIT_RX_RESET];
            data_q <= next_tx_shift[7] | (|mci_rst);
        end
    end

    assign avs_readdata_out = rdata;
    assign avs_waitrequest_out = wait_q;
    assign link_data_out = data_q;
    assign tx_reset_out = rst_tx_q;
    assign rx_reset_out = rst_rx_q;
    assign rx_active_out = active_q;
endmodule : gcirq_top
`default_nettype wire

// ---- core/gcirq_pkg.sv ----
`default_nettype none
package gcirq_pkg;
    // Register word addresses (one step per 32-bit register, not times four)
    localparam logic [3:0] ADDR_IRQ_STATUS0 = 4'h0;
    localparam logic [3:0] ADDR_IRQ_STATUS1 = 4'h1;
    localparam logic [3:0] ADDR_IRQ_STATUS2 = 4'h2;
    localparam logic [3:0] ADDR_COMMAND = 4'h3;
    localparam logic [3:0] ADDR_MON_TX1 = 4'h4;
    localparam logic [3:0] ADDR_MON_TX2 = 4'h5;
    localparam logic [3:0] ADDR_CI_RX1 = 4'h6;
    localparam logic [3:0] ADDR_CI_RX2 = 4'h7;
    localparam logic [3:0] ADDR_MON_RX1 = 4'h8;
    localparam logic [3:0] ADDR_MON_RX2 = 4'h9;
    localparam logic [3:0] ADDR_CONFIG = 4'hA;
    // Status 0 bits
    localparam int BIT_RX_MSG_END = 7;
    localparam int BIT_RX_POOL_FULL = 6;
    localparam int BIT_TX_POOL_READY = 4;
    localparam int BIT_RX_OVERFLOW = 2;
    localparam int BIT_TX_UNDERRUN = 1;
    // Status 1/2 bits, one register per channel
    localparam int BIT_CI_CHANGE = 5;
    localparam int BIT_MON_RX_VALID = 4;
    localparam int BIT_MON_RX_ABORT = 3;
    localparam int BIT_MON_EOM = 2;
    localparam int BIT_MON_TX_READY = 1;
    localparam int BIT_REMOTE_ABORT = 0;
    // Command bits
    localparam int BIT_TX_RESET = 0;
    localparam int BIT_RX_RESET = 1;
    localparam int BIT_MCI_RESET1 = 2;
    localparam int BIT_MCI_RESET2 = 3;
    // Config bits
    localparam int BIT_CLOCK_MODE = 0;
    // Reset values
    localparam logic [7:0] RESET_STATUS = 8'h00;
    localparam logic [7:0] RESET_COMMAND = 8'h00;
    localparam logic [7:0] RESET_CONFIG = 8'h00;
    // Frame and clock ratios
    localparam int FRAME_RATE_KHZ = 8;
    localparam int GCI_BITS_PER_N = 64;
    localparam int DOUBLE_BITS_PER_N = 16;
    localparam int SINGLE_BITS_PER_N = 8;
    localparam int GCI_N_MAX = 8;
    localparam int DS_N_MAX = 64;
    // Bits of one channel slot after frame sync
    localparam int SLOT_BITS = 8;
    typedef enum logic [1:0] {
        GCIRQ_TX_IDLE,
        GCIRQ_TX_WAIT_BYTE,
        GCIRQ_TX_SEND
    } gcirq_tx_state_t;
endpackage : gcirq_pkg
`default_nettype wire

// ---- bench/gcirq_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module gcirq_checker (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [3:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic avs_waitrequest_out,
    input wire logic rx_line_flag_in,
    input wire logic link_data_out,
    input wire logic tx_reset_out,
    input wire logic rx_reset_out,
    input wire logic rx_active_out
);
    logic cmd_w;
    logic mon_w;
    logic hunted;
    logic [5:0] fl;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    // Edge at which the command write is taken
    assign cmd_w = avs_write_in && avs_waitrequest_out &&
        avs_address_in == gcirq_pkg::ADDR_COMMAND;
    // History of line flags and of monitor writes
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            mon_w <= 1'b0;
            hunted <= 1'b0;
            fl <= 6'h00;
        end else begin
            mon_w <= mon_w | (avs_write_in && !avs_waitrequest_out &&
                avs_address_in[3:1] == 3'b010);
            hunted <= hunted | rx_reset_out;
            fl <= {fl[4:0], rx_line_flag_in};
        end
    end
    property p_wait_ans;
        (avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out;
    endproperty
    a_wait_ans: assert property (p_wait_ans) else $error("no answer after one wait state");
    property p_wait_one;
        !avs_waitrequest_out |=> avs_waitrequest_out;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("answer longer than one cycle");
    property p_rd_hi;
        avs_read_in && !avs_waitrequest_out |-> avs_readdata_out[31:8] == 24'h00_0000;
    endproperty
    a_rd_hi: assert property (p_rd_hi) else $error("upper read bits not zero");
    property p_tx_on;
        cmd_w && avs_writedata_in[gcirq_pkg::BIT_TX_RESET] |-> ##[1:2] tx_reset_out;
    endproperty
    a_tx_on: assert property (p_tx_on) else $error("tx reset not applied");
    property p_tx_off;
        cmd_w && !avs_writedata_in[gcirq_pkg::BIT_TX_RESET] |-> ##[1:2] !tx_reset_out;
    endproperty
    a_tx_off: assert property (p_tx_off) else $error("tx reset not released");
    property p_tx_keep;
        $changed(tx_reset_out) |-> $past(cmd_w) || $past(cmd_w, 2);
    endproperty
    a_tx_keep: assert property (p_tx_keep) else $error("tx reset changed alone");
    property p_rx_on;
        cmd_w && avs_writedata_in[gcirq_pkg::BIT_RX_RESET] |-> ##[1:2] rx_reset_out;
    endproperty
    a_rx_on: assert property (p_rx_on) else $error("rx reset not applied");
    property p_rx_hold;
        rx_reset_out |=> !rx_active_out;
    endproperty
    a_rx_hold: assert property (p_rx_hold) else $error("receiver runs in reset");
    property p_rx_hunt;
        $rose(rx_active_out) && hunted |-> |fl;
    endproperty
    a_rx_hunt: assert property (p_rx_hunt) else $error("receiver resumed without flag");
    property p_idle;
        !mon_w |-> link_data_out;
    endproperty
    a_idle: assert property (p_idle) else $error("line not idle");
endmodule : gcirq_checker
`default_nettype wire

// ---- bench/gcirq_partner.sv ----
`timescale 1ns/1ps
`default_nettype none
module gcirq_partner (
    input wire logic tx_in,
    input wire logic [7:0] ci_in,
    input wire logic [1:0] rab_in,
    output logic lclk_out = 1'b0,
    output logic fs_out = 1'b0,
    output logic rx_out = 1'b1,
    output logic [1:0] rab_out,
    output logic [7:0] mon_out = 8'hFF,
    output logic mon_ev_out = 1'b0
);
    int n = 0;
    logic [7:0] sh = 8'hFF;
    assign rab_out = rab_in;
    always #16 lclk_out = ~lclk_out;
    // Sync in bit 0, slot in bits 1 to 8, toggling data elsewhere
    always @(negedge lclk_out) begin
        n = (n + 1) % 16;
        fs_out <= (n == 0);
        rx_out <= (n >= 1 && n <= 8) ? ci_in[8-n] : ~rx_out;
    end
    always @(posedge lclk_out) begin
        if (n >= 1 && n <= 8) sh <= {sh[6:0], tx_in};
        if (n == 9) mon_out <= sh;
        mon_ev_out <= (n == 9) && sh !== 8'hFF && sh !== mon_out;
    end
endmodule : gcirq_partner
`default_nettype wire

// ---- bench/gcirq_top_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module gcirq_top_tb;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [3:0] adr = 4'h0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wd = 32'h0000_0000;
    logic [31:0] rdat;
    logic wt, lclk, fs, ldi, ldo, txr, rxr, act, mev;
    logic [1:0] remote_abort_flag = 2'b00;
    logic [1:0] rabw;
    logic [7:0] ci = 8'h00;
    logic [7:0] mon, s, b;
    logic [7:0] msk;
    logic [4:0] ev = 5'h00;
    logic lf = 1'b0;
    integer seed = 32'h9ea5_bb9f;
    int n_fail = 0;
    int samples_checked = 0;
    int bits[5] = '{7, 6, 4, 2, 1};
    logic [15:0] rq[$];
    logic [7:0] mq[$];
    always #2 clk_in = ~clk_in;
    gcirq_top u_dut (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .avs_address_in(adr),
        .avs_read_in(rd),
        .avs_write_in(wr),
        .avs_writedata_in(wd),
        .avs_readdata_out(rdat),
        .avs_waitrequest_out(wt),
        .link_clk_in(lclk),
        .frame_sync_in(fs),
        .link_data_in(ldi),
        .remote_abort_in(rabw),
        .tx_underrun_in(ev[0]),
        .tx_pool_free_in(ev[2]),
        .rx_msg_end_in(ev[4]),
        .rx_pool_full_in(ev[3]),
        .rx_overflow_in(ev[1]),
        .rx_line_flag_in(lf),
        .link_data_out(ldo),
        .tx_reset_out(txr),
        .rx_reset_out(rxr),
        .rx_active_out(act)
    );
    gcirq_partner u_far (
        .tx_in(ldo),
        .ci_in(ci),
        .rab_in(remote_abort_flag),
        .lclk_out(lclk),
        .fs_out(fs),
        .rx_out(ldi),
        .rab_out(rabw),
        .mon_out(mon),
        .mon_ev_out(mev)
    );
    task automatic stop_test;
        $display("checked %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : stop_test
    task automatic fail(input string m);
        n_fail++;
        $display("MISMATCH %0t %s", $time, m);
    endtask : fail
    // Reads note {mask, expected} for the watcher
    task automatic bus(input logic [3:0] a, input logic w, input logic [7:0] d,
        input logic [15:0] e);
        int k;
        @(posedge clk_in);
        adr <= a;
        wr <= w;
        rd <= ~w;
        wd <= {24'h00_0000, d};
        if (!w) rq.push_back(e);
        k = 0;
        do begin
            @(posedge clk_in);
            k++;
        end while (wt !== 1'b0 && k < 40);
        if (k >= 40) begin
            fail("bus timeout");
            stop_test();
        end
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus
    task automatic fire(input logic [7:0] m);
        @(posedge clk_in);
        ev <= {m[7], m[6], m[4], m[2], m[1]};
        repeat (4) @(posedge clk_in);
        ev <= 5'h00;
        repeat (4) @(posedge clk_in);
    endtask : fire
    task automatic chk_lvl(input logic g, input logic e);
        samples_checked++;
        if (g !== e) fail("level");
    endtask : chk_lvl
    task automatic wait_cy(input int n);
        repeat (n) @(posedge clk_in);
    endtask : wait_cy
    always @(posedge clk_in) begin
        if (rd && wt === 1'b0 && rq.size() > 0) begin
            msk = rq[0][15:8];
            samples_checked++;
            if ((rdat[7:0] & msk) !== (rq.pop_front() & msk)) fail("read value");
        end
    end
    always @(posedge mev) begin
        samples_checked++;
        if (mq.size() == 0 || mon !== mq.pop_front()) fail("monitor byte");
    end
    initial begin
        repeat (6) @(posedge clk_in);
        rst_n_in <= 1'b1;
        wait_cy(300);
        bus(gcirq_pkg::ADDR_IRQ_STATUS0, 0, 8'h00, 16'hFF00);
        bus(4'hF, 1, 8'hFF, 16'h0000);
        bus(4'hF, 0, 8'h00, 16'hFF00);
        fire(8'hD6);
        s = 8'hD6;
        bus(gcirq_pkg::ADDR_IRQ_STATUS0, 0, 8'h00, {8'hFF, s});
        foreach (bits[i]) begin
            s[bits[i]] = 1'b0;
            bus(gcirq_pkg::ADDR_IRQ_STATUS0, 1, ~(8'h01 << bits[i]), 16'h0000);
            bus(gcirq_pkg::ADDR_IRQ_STATUS0, 0, 8'h00, {8'hFF, s});
        end
        $display("status flags done");
        fire(8'hD6);
        bus(gcirq_pkg::ADDR_COMMAND, 1, 8'h02, 16'h0000);
        bus(gcirq_pkg::ADDR_IRQ_STATUS0, 0, 8'h00, 16'hFF12);
        bus(gcirq_pkg::ADDR_COMMAND, 1, 8'h01, 16'h0000);
        fire(8'h10);
        bus(gcirq_pkg::ADDR_IRQ_STATUS0, 0, 8'h00, 16'hFF02);
        chk_lvl(act, 1'b0);
        bus(gcirq_pkg::ADDR_COMMAND, 1, 8'h00, 16'h0000);
        fire(8'h10);
        bus(gcirq_pkg::ADDR_IRQ_STATUS0, 0, 8'h00, 16'hFF12);
        wait_cy(10);
        chk_lvl(act, 1'b0);
        lf <= 1'b1;
        wait_cy(4);
        lf <= 1'b0;
        wait_cy(10);
        chk_lvl(act, 1'b1);
        $display("software resets done");
        remote_abort_flag <= 2'b01;
        wait_cy(10);
        remote_abort_flag <= 2'b00;
        bus(gcirq_pkg::ADDR_IRQ_STATUS1, 0, 8'h00, 16'h0101);
        bus(gcirq_pkg::ADDR_MON_TX1, 1, 8'($random(seed)) & 8'h7F, 16'h0000);
        wait_cy(768);
        bus(gcirq_pkg::ADDR_IRQ_STATUS1, 1, 8'hFE, 16'h0000);
        bus(gcirq_pkg::ADDR_IRQ_STATUS1, 1, 8'hFD, 16'h0000);
        b = 8'($random(seed)) & 8'h7F;
        mq.push_back(b);
        bus(gcirq_pkg::ADDR_MON_TX1, 1, b, 16'h0000);
        wait_cy(768);
        bus(gcirq_pkg::ADDR_IRQ_STATUS1, 0, 8'h00, 16'h0302);
        $display("monitor transmit done");
        ci <= 8'($random(seed)) | 8'h01;
        wait_cy(640);
        bus(gcirq_pkg::ADDR_IRQ_STATUS1, 0, 8'h00, 16'h2020);
        bus(gcirq_pkg::ADDR_IRQ_STATUS1, 1, 8'hDF, 16'h0000);
        bus(gcirq_pkg::ADDR_CI_RX1, 0, 8'h00, {8'hFF, ci});
        bus(gcirq_pkg::ADDR_IRQ_STATUS1, 0, 8'h00, 16'h2000);
        ci <= ~ci;
        remote_abort_flag <= 2'b01;
        wait_cy(640);
        remote_abort_flag <= 2'b00;
        bus(gcirq_pkg::ADDR_IRQ_STATUS1, 0, 8'h00, 16'h2121);
        bus(gcirq_pkg::ADDR_COMMAND, 1, 8'h04, 16'h0000);
        bus(gcirq_pkg::ADDR_IRQ_STATUS1, 0, 8'h00, 16'h3F00);
        bus(gcirq_pkg::ADDR_COMMAND, 1, 8'h00, 16'h0000);
        bus(gcirq_pkg::ADDR_CONFIG, 1, 8'h01, 16'h0000);
        bus(gcirq_pkg::ADDR_COMMAND, 1, 8'h0C, 16'h0000);
        bus(gcirq_pkg::ADDR_IRQ_STATUS2, 0, 8'h00, 16'h3F00);
        bus(gcirq_pkg::ADDR_COMMAND, 1, 8'h00, 16'h0000);
        ci <= 8'($random(seed)) | 8'h01;
        wait_cy(640);
        bus(gcirq_pkg::ADDR_IRQ_STATUS2, 0, 8'h00, 16'h2020);
        bus(gcirq_pkg::ADDR_CI_RX2, 0, 8'h00, {8'hFF, ci});
        $display("command indicate and monitor reset done");
        wait_cy(20);
        stop_test();
    end
endmodule : gcirq_top_tb
bind gcirq_top gcirq_checker u_chk (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in),
    .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out),
    .rx_line_flag_in(rx_line_flag_in),
    .link_data_out(link_data_out),
    .tx_reset_out(tx_reset_out),
    .rx_reset_out(rx_reset_out),
    .rx_active_out(rx_active_out)
);
`default_nettype wire
